// ---- common/aais_pkg.sv ----
// Constants, field positions and types for the automatic downstream AIS control.
// Assumes a single 200 MHz clock domain and an AHB-Lite register bus.
package aais_pkg;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [31:0] FAST_IDX   = 32'h0000116B;
  localparam logic [31:0] SLOW_IDX   = 32'h00001163;
  localparam logic [31:0] CHCFG_IDX  = 32'h0000116C;
  localparam logic [31:0] STATUS_IDX = 32'h0000116D;
  localparam logic [31:0] FAST_ADDR   = {FAST_IDX[29:0], 2'b00};
  localparam logic [31:0] SLOW_ADDR   = {SLOW_IDX[29:0], 2'b00};
  localparam logic [31:0] CHCFG_ADDR  = {CHCFG_IDX[29:0], 2'b00};
  localparam logic [31:0] STATUS_ADDR = {STATUS_IDX[29:0], 2'b00};

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int unsigned BIT_EN      = 0;
  localparam int unsigned BIT_MSOUT   = 1;
  localparam int unsigned FAST_SF     = 2;
  localparam int unsigned FAST_SD     = 3;
  localparam int unsigned FAST_LOF    = 4;
  localparam int unsigned FAST_LOS    = 5;
  localparam int unsigned SLOW_LOS    = 1;
  localparam int unsigned SLOW_LOF    = 2;
  localparam int unsigned SLOW_SD     = 4;
  localparam int unsigned SLOW_SF     = 5;
  localparam int unsigned CHCFG_DS3_LSB = 8;

  // ********************************************************
  // Reset values and timing
  // ********************************************************
  localparam logic [5:0]  FAST_RST  = 6'h00;
  localparam logic [5:0]  SLOW_RST  = 6'h00;
  localparam logic [15:0] CHCFG_RST = 16'h0000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FAST_LIMIT_US = 125;
  localparam int unsigned FAST_LIMIT_CYC = FAST_LIMIT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLOW_FRAMES_DEF = 4;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic msais;
    logic los;
    logic lof;
    logic sd;
    logic sf;
  } aais_defect_t;

  typedef enum logic [0:0] {AIS_IDLE, AIS_SEND} aais_state_t;

endpackage

// ---- hw/aais_ctrl.sv ----
// Automatic downstream AIS control: turns receive section defects into AU-AIS
// or DS3 AIS requests for each tributary channel.
// Assumes defect levels and the frame pulse are synchronous to CLK.
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps

// Summary of operation
// - LOS trigger sends DS3 AIS on DS3 channels.
// - Triggers act only with master enable bit 0.
// - Fast triggers start AIS immediately, within 125us.
// - Slow register triggers start after several frames.
// - LOF trigger sends AU-AIS on STM-0 channels.
// - LOF trigger sends DS3 AIS on DS3 channels.
// - SD trigger sends AU-AIS on STM-0 channels.
// - SD trigger sends DS3 AIS; cleared bit blocks.
// - SF trigger sends AU-AIS on STM-0 channels.
// - Each channel's mode selects AU-AIS or DS3 AIS.
// - Cleared trigger bit gives no automatic AU-AIS.
// - Master enable also sends AIS on MS-AIS.
module aais_ctrl
  import aais_pkg::*;
#(
  parameter int unsigned NUM_CH         = 3,
  parameter int unsigned SLOW_FRAMES    = SLOW_FRAMES_DEF,
  parameter int unsigned FAST_LIMIT     = FAST_LIMIT_CYC
) (
  input  wire logic              CLK,        // Device clock, 200 MHz.
  input  wire logic              RESET,      // Synchronous reset, active high.
  input  wire logic [31:0]       HADDR,      // AHB address.
  input  wire logic [1:0]        HTRANS,     // AHB transfer type.
  input  wire logic              HWRITE,     // AHB write select.
  input  wire logic [2:0]        HSIZE,      // AHB transfer size.
  input  wire logic              HSEL,       // AHB slave select.
  input  wire logic              HREADY,     // AHB bus ready.
  input  wire logic [31:0]       HWDATA,     // AHB write data.
  output logic [31:0]            HRDATA,     // AHB read data.
  output logic                   HREADYOUT,  // AHB slave ready.
  output logic                   HRESP,      // AHB response, always OKAY.
  input  wire aais_defect_t      DEFECT,     // Receive section defect levels.
  input  wire logic              FRAME_SYNC, // One-cycle frame boundary pulse.
  output logic [NUM_CH-1:0]      AU_AIS,     // AU-AIS request per STM-0 channel.
  output logic [NUM_CH-1:0]      DS3_AIS     // DS3 AIS request per DS3 channel.
);

  localparam int unsigned CW = $clog2(SLOW_FRAMES + 1);

  // ********************************************************
  // Register state
  // ********************************************************
  logic [5:0]        fast_reg, next_fast_reg;
  logic [5:0]        slow_reg, next_slow_reg;
  logic [NUM_CH-1:0] chan_act, next_chan_act;
  logic [NUM_CH-1:0] chan_ds3, next_chan_ds3;
  logic              wr_pend, next_wr_pend;
  logic [31:0]       wr_addr, next_wr_addr;
  logic [31:0]       next_hrdata;
  logic              addr_ok;
  logic              rd_req;

  // ********************************************************
  // AIS state
  // ********************************************************
  aais_state_t       state, next_state;
  logic [CW-1:0]     slow_cnt, next_slow_cnt;
  logic [NUM_CH-1:0] next_au_ais, next_ds3_ais;
  logic              fast_cause, slow_cause, slow_armed, cause;
  logic [NUM_CH-1:0] stm_mask, ds_mask;

  // Only whole-word single transfers are expected; other sizes are still accepted.
  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign rd_req  = addr_ok && !HWRITE;

  // Bus slave: write data lands in the data phase, read data is registered.
  always_comb begin
    next_wr_pend  = addr_ok && HWRITE;
    next_wr_addr  = addr_ok ? HADDR : wr_addr;
    next_fast_reg = fast_reg;
    next_slow_reg = slow_reg;
    next_chan_act = chan_act;
    next_chan_ds3 = chan_ds3;
    if (wr_pend) begin
      // Trigger bits are plain read/write storage.
      if (wr_addr == FAST_ADDR) begin
        next_fast_reg = HWDATA[5:0];
      end else if (wr_addr == SLOW_ADDR) begin
        next_slow_reg = HWDATA[5:0];
      end else if (wr_addr == CHCFG_ADDR) begin
        next_chan_act = HWDATA[NUM_CH-1:0];
        next_chan_ds3 = HWDATA[CHCFG_DS3_LSB +: NUM_CH];
      end
    end
    // Reads use next values so a read right after a write sees the new data.
    next_hrdata = 32'h00000000;
    if (rd_req) begin
      if (HADDR == FAST_ADDR) begin
        next_hrdata[5:0] = next_fast_reg;
      end else if (HADDR == SLOW_ADDR) begin
        next_hrdata[5:0] = next_slow_reg;
      end else if (HADDR == CHCFG_ADDR) begin
        next_hrdata[NUM_CH-1:0]                 = next_chan_act;
        next_hrdata[CHCFG_DS3_LSB +: NUM_CH]    = next_chan_ds3;
      end else if (HADDR == STATUS_ADDR) begin
        next_hrdata[4:0]                 = DEFECT;
        next_hrdata[5]                   = (state == AIS_SEND);
        next_hrdata[6]                   = slow_armed;
        next_hrdata[8 +: NUM_CH]         = AU_AIS;
        next_hrdata[16 +: NUM_CH]        = DS3_AIS;
      end
    end
  end

  // Bus registers; the slave never inserts wait states.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fast_reg  <= FAST_RST;
      slow_reg  <= SLOW_RST;
      chan_act  <= CHCFG_RST[NUM_CH-1:0];
      chan_ds3  <= CHCFG_RST[CHCFG_DS3_LSB +: NUM_CH];
      wr_pend   <= 1'b0;
      wr_addr   <= 32'h00000000;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      fast_reg  <= next_fast_reg;
      slow_reg  <= next_slow_reg;
      chan_act  <= next_chan_act;
      chan_ds3  <= next_chan_ds3;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      HRDATA    <= next_hrdata;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Defect qualification. Each trigger bit needs the master enable as well,
  // and MS-AIS needs only the master enable.
  always_comb begin
    fast_cause = fast_reg[BIT_EN] && (
                 (fast_reg[FAST_LOS] && DEFECT.los) ||
                 (fast_reg[FAST_LOF] && DEFECT.lof) ||
                 (fast_reg[FAST_SD]  && DEFECT.sd)  ||
                 (fast_reg[FAST_SF]  && DEFECT.sf)  ||
                 DEFECT.msais);
    slow_cause = slow_reg[BIT_EN] && (
                 (slow_reg[SLOW_LOS] && DEFECT.los) ||
                 (slow_reg[SLOW_LOF] && DEFECT.lof) ||
                 (slow_reg[SLOW_SD]  && DEFECT.sd)  ||
                 (slow_reg[SLOW_SF]  && DEFECT.sf)  ||
                 DEFECT.msais);
  end

  // The slow path waits a number of frames; a defect that drops meanwhile
  // restarts the wait, which filters short hits at the cost of latency.
  // An armed count only acts while its qualified cause still stands, so
  // clearing the enable or the defect stops it in the same cycle.
  assign slow_armed = (slow_cnt == CW'(SLOW_FRAMES));
  assign cause      = fast_cause || (slow_armed && slow_cause);

  // Slow wait counter and send state, with per-channel routing by mode.
  always_comb begin
    next_slow_cnt = slow_cnt;
    if (!slow_cause) begin
      next_slow_cnt = '0;
    end else if (FRAME_SYNC && !slow_armed) begin
      next_slow_cnt = slow_cnt + CW'(1);
    end
    next_state = state;
    case (state)
      AIS_IDLE: begin
        if (cause) begin
          next_state = AIS_SEND;
        end
      end
      AIS_SEND: begin
        // Leaving only on a frame boundary keeps the outgoing frame whole.
        if (!cause && FRAME_SYNC) begin
          next_state = AIS_IDLE;
        end
      end
      default: next_state = AIS_IDLE;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      next_au_ais[i]  = (next_state == AIS_SEND) && next_chan_act[i] && !next_chan_ds3[i];
      next_ds3_ais[i] = (next_state == AIS_SEND) && next_chan_act[i] && next_chan_ds3[i];
    end
  end

  // AIS registers.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state    <= AIS_IDLE;
      slow_cnt <= '0;
      AU_AIS   <= '0;
      DS3_AIS  <= '0;
    end else begin
      state    <= next_state;
      slow_cnt <= next_slow_cnt;
      AU_AIS   <= next_au_ais;
      DS3_AIS  <= next_ds3_ais;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  assign stm_mask = chan_act & ~chan_ds3;
  assign ds_mask  = chan_act & chan_ds3;

  // Cycles a qualified fast defect has been waiting without AIS out.
  logic [31:0] fast_wait;
  always_ff @(posedge CLK) begin
    if (RESET || !fast_cause || state == AIS_SEND) begin
      fast_wait <= 32'h00000000;
    end else begin
      fast_wait <= fast_wait + 32'h00000001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_los_ds3_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_LOS] && DEFECT.los && !wr_pend
    |=> (DS3_AIS & ds_mask) == ds_mask)
    else $error("LOS did not raise DS3 AIS");
  a_master_gate: assert property (
    !fast_reg[BIT_EN] && !slow_reg[BIT_EN] && state == AIS_IDLE |=> state == AIS_IDLE)
    else $error("AIS started with master enable clear");
  a_fast_start: assert property (
    fast_cause |-> fast_wait < FAST_LIMIT)
    else $error("Fast AIS exceeded its start limit");
  a_slow_wait: assert property (
    state == AIS_IDLE && !fast_cause && slow_cnt == '0 |=> state == AIS_IDLE)
    else $error("Slow trigger started AIS without frame wait");
  a_lof_au_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_LOF] && DEFECT.lof && !wr_pend
    |=> (AU_AIS & stm_mask) == stm_mask)
    else $error("LOF did not raise AU-AIS");
  a_lof_ds3_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_LOF] && DEFECT.lof && !wr_pend
    |=> (DS3_AIS & ds_mask) == ds_mask)
    else $error("LOF did not raise DS3 AIS");
  a_sd_au_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_SD] && DEFECT.sd && !wr_pend
    |=> (AU_AIS & stm_mask) == stm_mask)
    else $error("SD did not raise AU-AIS");
  a_sd_ds3_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_SD] && $rose(DEFECT.sd) && !wr_pend
    |=> (DS3_AIS & ds_mask) == ds_mask)
    else $error("SD did not raise DS3 AIS");
  a_sf_au_out: assert property (
    fast_reg[BIT_EN] && fast_reg[FAST_SF] && DEFECT.sf && !wr_pend
    |=> (AU_AIS & stm_mask) == stm_mask)
    else $error("SF did not raise AU-AIS");
  a_mode_route: assert property (
    ((AU_AIS & chan_ds3) == '0) && ((DS3_AIS & ~chan_ds3) == '0))
    else $error("AIS sent on a channel of the wrong mode");
  a_no_trigger: assert property (
    state == AIS_IDLE && !cause |=> AU_AIS == '0 && DS3_AIS == '0)
    else $error("AIS sent without any enabled trigger");
  a_msais_out: assert property (
    fast_reg[BIT_EN] && DEFECT.msais |=> state == AIS_SEND)
    else $error("MS-AIS did not start AIS");
  a_hold_frame: assert property (
    state == AIS_SEND && !FRAME_SYNC |=> state == AIS_SEND)
    else $error("AIS ended away from a frame boundary");

  c_fast_send:  cover property (state == AIS_IDLE ##1 state == AIS_SEND);
  c_slow_armed: cover property (!fast_cause && $rose(slow_armed));
  c_frame_stop: cover property (state == AIS_SEND ##1 state == AIS_IDLE);
  c_mixed_mode: cover property (AU_AIS != '0 && DS3_AIS != '0);

endmodule

// ---- dv/aais_trib_model.sv ----
// Behavioural model of the downstream tributary transmitters.
// Assumes the AIS requests and the frame pulse are synchronous to CLK.
`timescale 1ns/10ps
module aais_trib_model #(
  parameter int unsigned NUM_CH = 3
) (
  input  wire logic              CLK,        // Device clock.
  input  wire logic              RESET,      // Synchronous reset, active high.
  input  wire logic              FRAME_SYNC, // Frame boundary pulse.
  input  wire logic [NUM_CH-1:0] AU_AIS,     // AU-AIS requests.
  input  wire logic [NUM_CH-1:0] DS3_AIS,    // DS3 AIS requests.
  output logic      [NUM_CH-1:0] TX_AIS      // Channels now sending AIS.
);
  // A transmitter swaps its payload only at a frame boundary, so a request
  // that comes and goes between two boundaries never reaches the line.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TX_AIS <= '0;
    end else if (FRAME_SYNC) begin
      TX_AIS <= AU_AIS | DS3_AIS;
    end
  end
endmodule

// ---- dv/aais_ctrl_tb_top.sv ----
// Self-checking testbench of the automatic downstream AIS control.
// Assumes one 200 MHz clock and a zero-wait-state AHB-Lite slave.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module aais_ctrl_tb_top;
  import aais_pkg::*;
  localparam int unsigned SF_N = 2;
  logic CLK, RESET, HWRITE, HSEL, FRAME_SYNC;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, seed;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, AU_AIS, DS3_AIS, TX_AIS, act, ds3;
  logic HREADYOUT, HRESP, cause;
  logic [5:0] f;
  aais_defect_t DEFECT, d;
  logic [31:0] addrs [4];
  int n_errors, n_tests, cyc;

  aais_ctrl #(.SLOW_FRAMES(SF_N), .FAST_LIMIT(4)) i_aais_ctrl (.CLK(CLK), .RESET(RESET),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HSEL(HSEL),
    .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .DEFECT(DEFECT), .FRAME_SYNC(FRAME_SYNC), .AU_AIS(AU_AIS),
    .DS3_AIS(DS3_AIS));
  aais_trib_model i_aais_trib_model (.CLK(CLK), .RESET(RESET), .FRAME_SYNC(FRAME_SYNC),
    .AU_AIS(AU_AIS), .DS3_AIS(DS3_AIS), .TX_AIS(TX_AIS));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Any enabled cause, fast register bits against the defect levels.
  function automatic logic exp_cause(input logic [5:0] r, input aais_defect_t d);
    return r[BIT_EN] & (d.msais | (d.los & r[FAST_LOS]) | (d.lof & r[FAST_LOF])
      | (d.sd & r[FAST_SD]) | (d.sf & r[FAST_SF]));
  endfunction
  // One single AHB transfer; waits on the slave's ready in both phases.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    `CHK("HRESP", 1'b0, HRESP)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic frame();
    @(posedge CLK);
    FRAME_SYNC <= 1'b1;
    @(posedge CLK);
    FRAME_SYNC <= 1'b0;
    wait_n(2);
  endtask
  task automatic chk_ais(input logic c);
    `CHK("AU_AIS", act & ~ds3 & {3{c}}, AU_AIS)
    `CHK("DS3_AIS", act & ds3 & {3{c}}, DS3_AIS)
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  // Free-running clock; the timeout guards every wait on the bus.
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {HWRITE, HSEL, FRAME_SYNC, HADDR, HWDATA, HTRANS, DEFECT} = '0;
    HSIZE = 3'b010;
    RESET = 1'b1;
    seed = 32'h1FB7;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    // Reset values, and an unmapped place that reads as zero.
    addrs = '{FAST_ADDR, SLOW_ADDR, CHCFG_ADDR, STATUS_ADDR + 32'h4};
    foreach (addrs[k]) begin
      ahb(1'b0, addrs[k], 32'h0);
      `CHK("reset read", 32'h0, rd)
    end
    // Trigger bits read back whatever software wrote.
    repeat (6) begin
      seed = xs(seed);
      ahb(1'b1, FAST_ADDR, {26'h0, seed[5:0]});
      ahb(1'b0, FAST_ADDR, 32'h0);
      `CHK("fast readback", {26'h0, seed[5:0]}, rd)
    end
    // Corner cases first, then random registers, channels and defects.
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      {act, ds3} = seed[13:8];
      f = seed[5:0];
      d = aais_defect_t'(seed[20:16]);
      if (i < 4) {f, d} = {6'h01 | (6'h04 << i), 5'h01 << i};
      else if (i < 8) {f, d} = {6'h04 << (i - 4), 5'h01 << (i - 4)};
      else if (i == 8) {f, d} = {6'h01, 5'h10};
      else if (i == 9) {f, d} = {6'h37, 5'h02};
      // Configure first, so the old trigger bits never meet the new defects.
      ahb(1'b1, CHCFG_ADDR, {21'h0, ds3, 5'h0, act});
      ahb(1'b1, FAST_ADDR, {26'h0, f});
      DEFECT <= d;
      cause = exp_cause(f, d);
      wait_n(1);
      chk_ais(cause);
      frame();
      chk_ais(cause);
      `CHK("TX_AIS", act & {3{cause}}, TX_AIS)
      DEFECT <= '0;
      wait_n(2);
      chk_ais(cause);
      frame();
      chk_ais(1'b0);
    end
    // Slow register: the same end state, reached only after frames.
    act = 3'h7;
    ds3 = 3'h5;
    ahb(1'b1, CHCFG_ADDR, 32'h00000507);
    ahb(1'b1, FAST_ADDR, 32'h0);
    ahb(1'b1, SLOW_ADDR, 32'h3);
    DEFECT <= 5'h08;
    wait_n(3);
    repeat (SF_N) begin
      chk_ais(1'b0);
      frame();
    end
    wait_n(1);
    chk_ais(1'b1);
    ahb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status", 32'h00050268, rd)
    DEFECT <= '0;
    frame();
    chk_ais(1'b0);
    stop_test();
  end
endmodule
